// >>> cdc_charge_detect.v
// two-channel charge controller and current-flow detector register and pin logic
//
// Notes on behaviour
// [R1] low coarse codes: 5 mV, then 50 mV steps
// [R2] bit 7 mirrors coarse range below centre
// [R3] fine bits pick (n+1)/8, 7 maximum
// [R4] invert bits flip each comparator output
// [R5] status bits raw comparators, writes ignored
// [R6] channel A enable moves pins to charge
// [R7] channel B enable moves port D pins
// [R8] control bits 7 and 3 read zero
// [R9] two full read/write 8-bit level registers
// [R10] detection works and wakes during sleep
// [R11] either comparator sets flag, enable gates irq
// [R12] firmware reads status to find source
// [R13] firmware programs opposite polarity levels
// [R14] wake works with channel A enable clear
// [R15] firmware clears power-off and bias-off bits
// [R16] pin enable never gates dac or comparator
// [R17] bits 7:3 coarse tap, 2:0 fine
// [R18] wake flag sticky until firmware clears
//
// Local design decision: the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none
`include "cdc_defs.vh"

module cdc_charge_detect
(
    // clock and reset
    input  wire        clk_sys_i,
    input  wire        rst_n_i,
    // register port
    input  wire [7:0]  reg_addr_i,
    input  wire [7:0]  reg_wdata_i,
    input  wire        reg_wr_i,
    input  wire        reg_rd_i,
    output reg  [7:0]  reg_rdata_o,
    // analog comparator results, synchronous
    input  wire        comparator_a_i,
    input  wire        comparator_b_i,
    // port C / D latch values for shared pins
    input  wire [1:0]  port_c_out_i,
    input  wire [1:0]  port_d_out_i,
    // level codes and analog power controls
    output reg  [7:0]  dac_a_level_code_o,
    output reg  [7:0]  dac_b_level_code_o,
    output reg         detector_power_off_o,
    output reg         sense_bias_off_o,
    // shared pins: port C bit0 dac output / bit1 comparator pin, port D bit0 comparator / bit1 dac output
    output reg         comparator_a_pin_o,
    output reg         comparator_b_pin_o,
    output reg         dac_a_pin_sel_o,
    output reg         dac_b_pin_sel_o,
    output reg  [1:0]  port_c_pin_o,
    output reg  [1:0]  port_d_pin_o,
    // wake and interrupt
    output reg         current_wake_flag_o,
    output reg         wake_irq_o
);
    // registers
    reg [7:0] dac_a_level_select;
    reg [7:0] dac_b_level_select;
    reg [7:0] ctrl_bits;
    reg [7:0] sleep_power_control;
    reg       current_wake_flag;
    reg       current_wake_irq_enable;
    reg       cmp_a_q;
    reg       cmp_b_q;

    wire        detect_on;
    wire        cmp_a_eff;
    wire        cmp_b_eff;
    wire        wake_event;
    wire [7:0]  ctrl_read;
    wire [14:0] level_a;
    wire [14:0] level_b;
    reg  [7:0]  next_rdata;

    // one decoder per channel; results kept as observation of the ladder taps
    cdc_level_decode u_dec_a
    (
        .code_i     (dac_a_level_select),
        .range_lo_o (),
        .range_hi_o (),
        .fine_sel_o (),
        .level_o    (level_a)
    );

    cdc_level_decode u_dec_b
    (
        .code_i     (dac_b_level_select),
        .range_lo_o (),
        .range_hi_o (),
        .fine_sel_o (),
        .level_o    (level_b)
    );

    // comparators run whenever powered, independent of pin enables
    assign detect_on = ~sleep_power_control[`CDC_SLP_DET_OFF]; // [R16]

    // polarity inversion after the raw status tap
    assign cmp_a_eff = detect_on & (cmp_a_q ^ ctrl_bits[`CDC_CTRL_INV_A]); // [R4]
    assign cmp_b_eff = detect_on & (cmp_b_q ^ ctrl_bits[`CDC_CTRL_INV_B]); // [R4]

    // either channel may wake, no clock gating so this works in sleep
    assign wake_event = cmp_a_eff | cmp_b_eff; // [R10] [R11] [R14]

    // status bits show raw comparators, unimplemented bits are zero
    assign ctrl_read = {1'b0, cmp_b_q, ctrl_bits[5:4], 1'b0, cmp_a_q, ctrl_bits[1:0]}; // [R5] [R8]

    // register writes; status bits are not stored so writes cannot touch them
    always @(posedge clk_sys_i)
    begin
        if (!rst_n_i)
        begin
            dac_a_level_select      <= `CDC_RST_DAC;
            dac_b_level_select      <= `CDC_RST_DAC;
            ctrl_bits               <= `CDC_RST_CTRL;
            sleep_power_control     <= `CDC_RST_SLEEP_PWR;
            current_wake_irq_enable <= 1'b0;
        end
        else if (reg_wr_i)
        begin
            case (reg_addr_i)
                `CDC_ADDR_DAC_A:     dac_a_level_select <= reg_wdata_i; // [R9]
                `CDC_ADDR_DAC_B:     dac_b_level_select <= reg_wdata_i; // [R9]
                `CDC_ADDR_CTRL:      ctrl_bits <= reg_wdata_i & `CDC_CTRL_WR_MASK; // [R5]
                `CDC_ADDR_SLEEP_PWR: sleep_power_control <= reg_wdata_i & `CDC_SLP_WR_MASK;
                `CDC_ADDR_IRQ_EN:    current_wake_irq_enable <= reg_wdata_i[`CDC_IRQ_WAKE];
                default:             ;
            endcase
        end
    end

    // comparator sample; inputs are already synchronous
    always @(posedge clk_sys_i)
    begin
        if (!rst_n_i)
        begin
            cmp_a_q <= 1'b0;
            cmp_b_q <= 1'b0;
        end
        else
        begin
            cmp_a_q <= comparator_a_i & detect_on;
            cmp_b_q <= comparator_b_i & detect_on;
        end
    end

    // sticky wake flag; a new event beats a firmware clear in the same cycle
    always @(posedge clk_sys_i)
    begin
        if (!rst_n_i)
            current_wake_flag <= 1'b0;
        else if (wake_event)
            current_wake_flag <= 1'b1; // [R18] [R11]
        else if (reg_wr_i && reg_addr_i == `CDC_ADDR_IRQ_REQ && !reg_wdata_i[`CDC_IRQ_WAKE])
            current_wake_flag <= 1'b0; // [R18]
    end

    // read mux, unmapped addresses read zero
    always @*
    begin
        next_rdata = 8'h00;
        case (reg_addr_i)
            `CDC_ADDR_DAC_A:     next_rdata = dac_a_level_select;
            `CDC_ADDR_DAC_B:     next_rdata = dac_b_level_select;
            `CDC_ADDR_CTRL:      next_rdata = ctrl_read; // [R5] [R8]
            `CDC_ADDR_SLEEP_PWR: next_rdata = sleep_power_control;
            `CDC_ADDR_IRQ_REQ:   next_rdata = {current_wake_flag, 7'h00};
            `CDC_ADDR_IRQ_EN:    next_rdata = {current_wake_irq_enable, 7'h00};
            default:             next_rdata = 8'h00;
        endcase
    end

    // read data held only in the cycle after the strobe
    always @(posedge clk_sys_i)
    begin
        if (!rst_n_i)
            reg_rdata_o <= 8'h00;
        else if (reg_rd_i)
            reg_rdata_o <= next_rdata;
        else
            reg_rdata_o <= 8'h00;
    end

    // registered outputs: pin muxing, codes, power controls, irq
    always @(posedge clk_sys_i)
    begin
        if (!rst_n_i)
        begin
            dac_a_level_code_o   <= 8'h00;
            dac_b_level_code_o   <= 8'h00;
            detector_power_off_o <= 1'b0;
            sense_bias_off_o     <= 1'b0;
            comparator_a_pin_o   <= 1'b0;
            comparator_b_pin_o   <= 1'b0;
            dac_a_pin_sel_o      <= 1'b0;
            dac_b_pin_sel_o      <= 1'b0;
            port_c_pin_o         <= 2'h0;
            port_d_pin_o         <= 2'h0;
            current_wake_flag_o  <= 1'b0;
            wake_irq_o           <= 1'b0;
        end
        else
        begin
            dac_a_level_code_o   <= dac_a_level_select; // [R17]
            dac_b_level_code_o   <= dac_b_level_select; // [R17]
            detector_power_off_o <= sleep_power_control[`CDC_SLP_DET_OFF];
            sense_bias_off_o     <= sleep_power_control[`CDC_SLP_BIAS_OFF];
            // channel A pins: dac output on pin 0, comparator on pin 1
            dac_a_pin_sel_o      <= ctrl_bits[`CDC_CTRL_EN_A]; // [R6]
            comparator_a_pin_o   <= cmp_a_eff;
            port_c_pin_o[0]      <= ctrl_bits[`CDC_CTRL_EN_A] ? 1'b0 : port_c_out_i[0]; // [R6]
            port_c_pin_o[1]      <= ctrl_bits[`CDC_CTRL_EN_A] ? cmp_a_eff : port_c_out_i[1]; // [R6]
            // channel B pins: comparator on pin 0, dac output on pin 1
            dac_b_pin_sel_o      <= ctrl_bits[`CDC_CTRL_EN_B]; // [R7]
            comparator_b_pin_o   <= cmp_b_eff;
            port_d_pin_o[0]      <= ctrl_bits[`CDC_CTRL_EN_B] ? cmp_b_eff : port_d_out_i[0]; // [R7]
            port_d_pin_o[1]      <= ctrl_bits[`CDC_CTRL_EN_B] ? 1'b0 : port_d_out_i[1]; // [R7]
            current_wake_flag_o  <= current_wake_flag;
            wake_irq_o           <= current_wake_flag & current_wake_irq_enable; // [R11]
        end
    end

    // decoded levels do not leave this module; reduced into an unused wire on purpose
    wire unused_levels;
    assign unused_levels = ^{level_a, level_b};
endmodule
`default_nettype wire

// >>> cdc_defs.vh
// register map, field positions, reset values and decode constants for the charge/detect block
`ifndef CDC_DEFS_VH
`define CDC_DEFS_VH

// register addresses
`define CDC_ADDR_DAC_A        8'h9B
`define CDC_ADDR_DAC_B        8'h9C
`define CDC_ADDR_CTRL         8'h9D
`define CDC_ADDR_SLEEP_PWR    8'h8F
`define CDC_ADDR_IRQ_REQ      8'h0C
`define CDC_ADDR_IRQ_EN       8'h8C

// reset values
`define CDC_RST_DAC           8'h00
`define CDC_RST_CTRL          8'h00
`define CDC_RST_SLEEP_PWR     8'h00
`define CDC_RST_IRQ           8'h00

// control register fields
`define CDC_CTRL_INV_A        0
`define CDC_CTRL_EN_A         1
`define CDC_CTRL_STAT_A       2
`define CDC_CTRL_INV_B        4
`define CDC_CTRL_EN_B         5
`define CDC_CTRL_STAT_B       6
`define CDC_CTRL_WR_MASK      8'h33

// sleep power control fields
`define CDC_SLP_DET_OFF       3
`define CDC_SLP_BIAS_OFF      4
`define CDC_SLP_WR_MASK       8'h18

// interrupt request / enable field
`define CDC_IRQ_WAKE          7

// coarse decode: codes below this use 5 mV steps, codes at or above it 50 mV steps
`define CDC_COARSE_SPLIT      4'hA
// coarse range bounds in units of 0.5 mV, centre 0.5000 V
`define CDC_MID_HALF_MV       12'h3E8
`define CDC_FINE_STEP_HALF_MV 12'h00A
`define CDC_WIDE_STEP_HALF_MV 12'h064
`define CDC_FINE_SPAN_HALF_MV 12'h064
`define CDC_FINE_MAX          3'h7

`endif

// >>> cdc_level_decode.v
// decodes one dac level code into coarse range bounds and fine target level
`timescale 1ns/1ps
`default_nettype none
`include "cdc_defs.vh"

module cdc_level_decode
(
    // level code
    input  wire [7:0]  code_i,
    // decoded range, units of 0.5 mV
    output reg  [11:0] range_lo_o,
    output reg  [11:0] range_hi_o,
    output reg  [2:0]  fine_sel_o,
    output reg  [14:0] level_o
);
    reg [3:0]  step_idx;
    reg [11:0] offs_lo;
    reg [11:0] offs_hi;
    reg [14:0] span;

    // coarse tap from code bits 7:3, fine fraction from bits 2:0
    always @*
    begin
        step_idx = code_i[6:3];
        if (step_idx < `CDC_COARSE_SPLIT) // [R1]
        begin
            offs_lo = {8'h00, step_idx} * `CDC_FINE_STEP_HALF_MV;
            offs_hi = offs_lo + `CDC_FINE_STEP_HALF_MV;
        end
        else
        begin
            offs_lo = `CDC_FINE_SPAN_HALF_MV
                + {8'h00, step_idx - `CDC_COARSE_SPLIT} * `CDC_WIDE_STEP_HALF_MV;
            offs_hi = offs_lo + `CDC_WIDE_STEP_HALF_MV;
        end
        // bit 7 mirrors the range below the centre voltage
        if (code_i[7]) // [R2]
        begin
            range_lo_o = `CDC_MID_HALF_MV - offs_hi;
            range_hi_o = `CDC_MID_HALF_MV - offs_lo;
        end
        else
        begin
            range_lo_o = `CDC_MID_HALF_MV + offs_lo;
            range_hi_o = `CDC_MID_HALF_MV + offs_hi;
        end
        fine_sel_o = code_i[2:0]; // [R17]
        // (n+1)/8 of range maximum, code 7 gives the maximum itself
        span = {3'h0, range_hi_o} * {12'h000, (fine_sel_o + 3'h1)} ; // [R3]
        if (fine_sel_o == `CDC_FINE_MAX)
            level_o = {3'h0, range_hi_o};
        else
            level_o = span >> 3;
    end
endmodule
`default_nettype wire

// >>> cdc_charge_detect_sva.sv
// assertion checker for the charge/detect register and pin logic
`timescale 1ns/1ps
`default_nettype none
module cdc_charge_detect_sva
(
    // clock and reset
    input wire logic       clk_sys_i,
    input wire logic       rst_n_i,
    // register port
    input wire logic [7:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic       reg_wr_i,
    input wire logic       reg_rd_i,
    input wire logic [7:0] reg_rdata_o,
    // level code and pins
    input wire logic [7:0] dac_a_level_code_o,
    input wire logic       comparator_a_pin_o,
    input wire logic       comparator_b_pin_o,
    input wire logic       dac_a_pin_sel_o,
    input wire logic       dac_b_pin_sel_o,
    input wire logic [1:0] port_c_pin_o,
    input wire logic [1:0] port_d_pin_o,
    // wake
    input wire logic       current_wake_flag_o,
    input wire logic       wake_irq_o
);
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (!rst_n_i);

    a_spare_bits_zero: assert property (
        reg_rd_i && reg_addr_i == 8'h9D |=> !reg_rdata_o[7] && !reg_rdata_o[3])
        else $error("spare control bit set");
    a_rdata_quiet: assert property (
        !reg_rd_i |=> reg_rdata_o == 8'h00) else $error("read data without read");
    // gap cycle between write and read is the bench's habit
    a_ctrl_mask: assert property (
        reg_rd_i && reg_addr_i == 8'h9D && $past(reg_wr_i, 2) && !$past(reg_wr_i)
        && $past(reg_addr_i, 2) == 8'h9D && $past(rst_n_i) && $past(rst_n_i, 2)
        |=> (reg_rdata_o & 8'h33) == ($past(reg_wdata_i, 3) & 8'h33))
        else $error("control readback wrong");
    a_dac_a_copy: assert property (
        reg_wr_i && reg_addr_i == 8'h9B |-> ##2 dac_a_level_code_o == $past(reg_wdata_i, 2))
        else $error("level code not passed on");
    a_pin_c_mux: assert property (
        dac_a_pin_sel_o |-> port_c_pin_o == {comparator_a_pin_o, 1'b0})
        else $error("port c pins wrong");
    a_pin_d_mux: assert property (
        dac_b_pin_sel_o |-> port_d_pin_o == {1'b0, comparator_b_pin_o})
        else $error("port d pins wrong");
    a_irq_needs_flag: assert property (
        wake_irq_o |-> current_wake_flag_o) else $error("irq without flag");
    a_wake_sets_flag: assert property (
        comparator_a_pin_o || comparator_b_pin_o |-> ##[1:3] current_wake_flag_o)
        else $error("wake flag not set");
    // only a firmware write to the request register may drop the flag
    a_flag_sticky: assert property (
        $fell(current_wake_flag_o) && $past(rst_n_i)
        |-> $past(reg_wr_i, 2) && $past(reg_addr_i, 2) == 8'h0C)
        else $error("wake flag dropped");
endmodule
`default_nettype wire

// >>> cdc_sense_model.sv
// sense resistor model: turns a commanded sense voltage into two comparator results
`timescale 1ns/1ps
`default_nettype none
module cdc_sense_model
(
    // clock
    input  wire logic        clk_sys_i,
    // sense voltage in 0.5 mV units, level codes
    input  wire logic [11:0] sense_i,
    input  wire logic [7:0]  code_a_i,
    input  wire logic [7:0]  code_b_i,
    // comparator results
    output var  logic        comparator_a_o,
    output var  logic        comparator_b_o
);
    // top of the coarse range; fine fraction ignored, good enough for trips
    function automatic logic [11:0] top(input logic [7:0] c);
        logic [11:0] m;
        m = {8'h00, c[6:3]};
        if (!c[7])
            return (m < 12'h00A) ? 12'h3E8 + 12'h00A * (m + 12'h001)
                                 : 12'h44C + 12'h064 * (m - 12'h009);
        return (m < 12'h00A) ? 12'h3E8 - 12'h00A * m : 12'h384 - 12'h064 * (m - 12'h00A);
    endfunction

    // results move just after the edge like a synchronised analog output
    always @(posedge clk_sys_i)
    begin
        comparator_a_o <= sense_i > top(code_a_i);
        comparator_b_o <= sense_i > top(code_b_i);
    end
endmodule
`default_nettype wire

// >>> tb_cdc_charge_detect.sv
// self-checking bench for the charge/detect register and pin logic
`timescale 1ns/1ps
`default_nettype none
module tb_cdc_charge_detect;
    logic        clk_sys_i = 1'b0;
    logic        rst_n_i = 1'b0;
    logic [7:0]  reg_addr_i = 8'h00;
    logic [7:0]  reg_wdata_i = 8'h00;
    logic        reg_wr_i = 1'b0;
    logic        reg_rd_i = 1'b0;
    logic [1:0]  port_c_out_i = 2'b11;
    logic [1:0]  port_d_out_i = 2'b10;
    logic [11:0] sense = 12'h3C0;
    logic [7:0]  rv;
    wire  [7:0]  reg_rdata_o, dac_a_level_code_o, dac_b_level_code_o;
    wire  [1:0]  port_c_pin_o, port_d_pin_o;
    wire         comparator_a_i, comparator_b_i, comparator_a_pin_o, comparator_b_pin_o;
    wire         detector_power_off_o, sense_bias_off_o, dac_a_pin_sel_o, dac_b_pin_sel_o;
    wire         current_wake_flag_o, wake_irq_o;
    int          n_fail = 0;
    int          samples_checked = 0;

    always #5 clk_sys_i = ~clk_sys_i;

    cdc_charge_detect dut
    (
        .clk_sys_i, .rst_n_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i, .reg_rdata_o,
        .comparator_a_i, .comparator_b_i, .port_c_out_i, .port_d_out_i,
        .dac_a_level_code_o, .dac_b_level_code_o, .detector_power_off_o, .sense_bias_off_o,
        .comparator_a_pin_o, .comparator_b_pin_o, .dac_a_pin_sel_o, .dac_b_pin_sel_o,
        .port_c_pin_o, .port_d_pin_o, .current_wake_flag_o, .wake_irq_o
    );
    cdc_sense_model model
    (
        .clk_sys_i, .sense_i(sense), .code_a_i(dac_a_level_code_o),
        .code_b_i(dac_b_level_code_o), .comparator_a_o(comparator_a_i),
        .comparator_b_o(comparator_b_i)
    );

    task automatic tally_and_finish;
        if (n_fail == 0 && samples_checked > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            n_fail++;
            $display("[FAIL] %0t got %h want %h", $time, got, exp);
        end
    endtask
    // each access leaves one idle cycle so strobes never toggle twice per step
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        reg_addr_i <= a;
        reg_wdata_i <= d;
        reg_wr_i <= 1'b1;
        @(posedge clk_sys_i);
        reg_wr_i <= 1'b0;
        @(posedge clk_sys_i);
    endtask
    task automatic rdchk(input logic [7:0] a, input logic [7:0] e);
        reg_addr_i <= a;
        reg_rd_i <= 1'b1;
        @(posedge clk_sys_i);
        reg_rd_i <= 1'b0;
        #1 rv = reg_rdata_o;
        chk(rv, e);
        @(posedge clk_sys_i);
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clk_sys_i);
        #1;
    endtask
    task automatic wait_flag;
        int i;
        for (i = 0; i < 10 && current_wake_flag_o !== 1'b1; i++)
            cyc(1);
        if (i == 10)
        begin
            n_fail++;
            $display("[FAIL] %0t wake flag timeout", $time);
            tally_and_finish();
        end
        else
            @(posedge clk_sys_i);
    endtask

    task automatic s_reset_and_levels;
        rdchk(8'h9B, 8'h00);
        rdchk(8'h9D, 8'h00);
        rdchk(8'h50, 8'h00);
        wr(8'h9B, 8'hA5);
        wr(8'h9C, 8'h5A);
        rdchk(8'h9B, 8'hA5);
        rdchk(8'h9C, 8'h5A);
        chk(dac_b_level_code_o, 8'h5A);
    endtask
    // sense above dac A top, both inverted and both pin functions on
    task automatic s_ctrl_and_pins;
        sense <= 12'h3E8;
        wr(8'h9D, 8'hFF);
        rdchk(8'h9D, 8'h37);
        cyc(2);
        chk(comparator_a_pin_o, 8'h00);
        chk(comparator_b_pin_o, 8'h01);
        chk(port_c_pin_o, 8'h00);
        chk(port_d_pin_o, 8'h01);
        chk(dac_a_pin_sel_o, 8'h01);
        chk(dac_b_pin_sel_o, 8'h01);
        chk(dac_a_level_code_o, 8'hA5);
        wr(8'h9D, 8'h00);
        cyc(2);
        chk(port_c_pin_o, 8'h03);
        chk(port_d_pin_o, 8'h02);
        chk(dac_a_pin_sel_o, 8'h00);
        chk(dac_b_pin_sel_o, 8'h00);
        chk(comparator_a_pin_o, 8'h01);
    endtask
    task automatic s_wake;
        sense <= 12'h3C0;
        cyc(4);
        wr(8'h0C, 8'h00);
        rdchk(8'h0C, 8'h00);
        wr(8'h8C, 8'h80);
        chk(wake_irq_o, 8'h00);
        sense <= 12'h3E8;
        wait_flag();
        cyc(2);
        chk(wake_irq_o, 8'h01);
        rdchk(8'h9D, 8'h04);
        sense <= 12'h3C0;
        wr(8'h0C, 8'h80);
        cyc(3);
        chk(current_wake_flag_o, 8'h01);
        wr(8'h0C, 8'h00);
        cyc(2);
        chk(current_wake_flag_o, 8'h00);
        wr(8'h9C, 8'hD0);
        wr(8'h9D, 8'h10);
        sense <= 12'h370;
        wait_flag();
        rdchk(8'h9D, 8'h10);
        wr(8'h8C, 8'h00);
        cyc(2);
        chk(wake_irq_o, 8'h00);
    endtask
    task automatic s_power;
        wr(8'h8F, 8'h08);
        wr(8'h0C, 8'h00);
        cyc(4);
        chk(detector_power_off_o, 8'h01);
        chk(current_wake_flag_o, 8'h00);
        wr(8'h8F, 8'h10);
        rdchk(8'h8F, 8'h10);
        chk(sense_bias_off_o, 8'h01);
        wait_flag();
    endtask

    initial
    begin
        repeat (16) @(posedge clk_sys_i);
        rst_n_i <= 1'b1;
        @(posedge clk_sys_i);
        s_reset_and_levels();
        s_ctrl_and_pins();
        s_wake();
        s_power();
        tally_and_finish();
    end
endmodule

bind cdc_charge_detect cdc_charge_detect_sva chk_sva
(
    .clk_sys_i, .rst_n_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i, .reg_rdata_o,
    .dac_a_level_code_o, .comparator_a_pin_o, .comparator_b_pin_o, .dac_a_pin_sel_o,
    .dac_b_pin_sel_o, .port_c_pin_o, .port_d_pin_o, .current_wake_flag_o, .wake_irq_o
);
`default_nettype wire
